/* rtl/rfsrb_regbank.sv */
`timescale 1ns/1ps
`default_nettype none
module rfsrb_regbank
  import rfsrb_pkg::*;
(
  input  wire logic        core_clk_in,          // 100 MHz core clock
  input  wire logic        rst_in,               // Synchronous reset, active high
  input  wire logic        serial_select_n_in,   // Access select, active low
  input  wire logic        serial_clk_in,        // Serial clock from host
  input  wire logic        serial_data_in,       // Data pin input level
  output logic             serial_data_out,      // Data pin drive value
  output logic             serial_data_oe_n_out, // Data pin drive enable, low drives
  input  wire logic [30:0] status_flags_in,      // Status word from radio core
  input  wire logic        synth_lock_flag_in,   // Synthesizer lock flag
  input  wire logic [31:0] wakeup_word_in,       // Received wake-up word
  input  wire logic [5:0]  signal_level_in,      // Measured signal level
  input  wire logic        radio_data_pin_in,    // Demodulated data
  output logic             radio_data_pin_out,   // Validated received data
  output rfsrb_ctrl_t      ctrl_out              // Decoded radio controls
);

  rfsrb_state_t  state_ff;
  logic [2:0]    sel_sync_ff;
  logic [2:0]    sck_sync_ff;
  logic [1:0]    sdi_sync_ff;
  logic [3:0]    addr_ff;
  logic [2:0]    hdr_cnt_ff;
  logic [5:0]    bit_cnt_ff;
  logic [31:0]   shift_ff;
  logic          invalid_ff;
  logic [5:0]    width_ff;
  logic [31:0]   regs_ff [16];
  logic          soft_rst_ff;
  logic          data_valid_ff;
  logic          oe_n_ff;
  logic          sdo_ff;

  logic          sel_active;
  logic          sck_rise;
  logic          sck_fall;
  logic          sdi;
  logic          read_begin;
  logic          write_commit;
  logic          end_access;
  logic [5:0]    cur_width;
  logic [31:0]   cur_value;
  logic [31:0]   merged;
  logic [31:0]   main_ctrl;
  logic [7:0]    thr;
  logic [7:0]    hys;
  logic [7:0]    lvl;

  // Width of the register as seen by the serial port; zero marks invalid
  function automatic logic [5:0] width_of(input logic [3:0] adr, input logic rd);
    logic [5:0] w;
    w = WID_NONE;
    if (adr <= ADR_FREQ_CODE_3 || adr == ADR_MAIN_CTRL || adr == ADR_WAKEUP_CTRL ||
        adr == ADR_LOCK_CTRL) begin
      w = WID_FULL;
    end else if (adr == ADR_STATUS || adr == ADR_WAKEUP_WORD) begin
      w = rd ? ((adr == ADR_STATUS) ? WID_STATUS : WID_FULL) : WID_NONE;
    end else if (adr == ADR_SLICER_TRIM) begin
      w = WID_SLICER;
    end else if (adr == ADR_WAKEUP_RATE) begin
      w = WID_WU_RATE;
    end else if (adr == ADR_WAKEUP_ADDR) begin
      w = WID_WU_ADDR;
    end else if (adr == ADR_SW_CLEAR) begin
      w = rd ? WID_NONE : WID_SW_CLEAR;
    end
    // Reserved 1100-1110 fall through as invalid
    return w;
  endfunction

  // Default value of each register
  function automatic logic [31:0] default_of(input int idx);
    logic [31:0] v;
    v = RST_OTHER;
    if (idx == int'(ADR_MAIN_CTRL)) begin
      v = RST_MAIN_CTRL;
    end else if (idx == int'(ADR_SLICER_TRIM)) begin
      v = RST_SLICER;
    end
    return v;
  endfunction

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sel_sync_ff <= 3'h7;
      sck_sync_ff <= 3'h0;
      sdi_sync_ff <= 2'h0;
    end else begin
      sel_sync_ff <= {sel_sync_ff[1:0], serial_select_n_in};
      sck_sync_ff <= {sck_sync_ff[1:0], serial_clk_in};
      sdi_sync_ff <= {sdi_sync_ff[0], serial_data_in};
    end
  end

  // Edge detection on synchronised pins; clock ignored while deselected
  assign sel_active = ~sel_sync_ff[1];
  assign sck_rise   = sel_active & sck_sync_ff[1] & ~sck_sync_ff[2];
  assign sck_fall   = sel_active & ~sck_sync_ff[1] & sck_sync_ff[2];
  assign sdi        = sdi_sync_ff[1];
  assign end_access = ~sel_active & ~(state_ff == ST_IDLE);

  // Direction bit 0 after four address bits opens a read
  assign read_begin = (state_ff == ST_ADDR) & sck_rise &
                      (hdr_cnt_ff == ADDR_RW_LAST) & ~sdi;
  assign cur_width  = width_of(addr_ff, 1'b1);
  assign main_ctrl  = regs_ff[ADR_MAIN_CTRL];

  // Read value of the addressed register, live inputs for read-only ones
  always_comb begin
    cur_value = regs_ff[addr_ff];
    if (addr_ff == ADR_STATUS) begin
      cur_value = {1'b0, status_flags_in};
    end else if (addr_ff == ADR_WAKEUP_WORD) begin
      cur_value = wakeup_word_in;
    end
  end

  // Write commits on select rise, or on the first extra rising edge
  assign write_commit = (state_ff == ST_WRITE) & (width_ff != WID_NONE) &
                        ((~sel_active & (bit_cnt_ff != 6'h00)) |
                         (sck_rise & (bit_cnt_ff == width_ff)));

  // Merge the received top bits over the old register contents
  always_comb begin
    logic [5:0]  keep;
    logic [31:0] keep_mask;
    logic [31:0] wid_mask;
    keep      = width_ff - bit_cnt_ff;
    keep_mask = (keep == 6'h00) ? 32'h0000_0000 : (32'hFFFF_FFFF >> (WID_FULL - keep));
    wid_mask  = 32'hFFFF_FFFF >> (WID_FULL - width_ff);
    merged    = (regs_ff[addr_ff] & keep_mask) | ((shift_ff << keep) & wid_mask);
  end

  // Access sequencer; select high always returns to idle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (sel_active) begin
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (~sel_active) begin
            state_ff <= ST_IDLE;
          end else if (sck_rise && hdr_cnt_ff == ADDR_RW_LAST) begin
            state_ff <= sdi ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          if (~sel_active) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (~sel_active) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Header capture: four address bits then direction, MSB first
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      addr_ff    <= 4'h0;
      hdr_cnt_ff <= 3'h0;
    end else if (state_ff == ST_IDLE) begin
      hdr_cnt_ff <= 3'h0;
    end else if (state_ff == ST_ADDR && sck_rise) begin
      hdr_cnt_ff <= hdr_cnt_ff + 3'h1;
      if (hdr_cnt_ff != ADDR_RW_LAST) begin
        addr_ff <= {addr_ff[2:0], sdi};
      end
    end
  end

  // Data shifter and bit counter for both directions
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      shift_ff   <= 32'h0000_0000;
      bit_cnt_ff <= 6'h00;
      width_ff   <= 6'h00;
      invalid_ff <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      bit_cnt_ff <= 6'h00;
    end else if (state_ff == ST_ADDR && sck_rise && hdr_cnt_ff == ADDR_RW_LAST) begin
      bit_cnt_ff <= 6'h00;
      width_ff   <= width_of(addr_ff, ~sdi);
      invalid_ff <= (width_of(addr_ff, ~sdi) == WID_NONE);
      shift_ff   <= ~sdi ? (cur_value << (WID_FULL - cur_width)) : 32'h0000_0000;
    end else if (state_ff == ST_READ && sck_fall) begin
      shift_ff   <= {shift_ff[30:0], 1'b0};
      bit_cnt_ff <= (bit_cnt_ff == CNT_MAX) ? CNT_MAX : bit_cnt_ff + 6'h01;
    end else if (state_ff == ST_WRITE && sck_rise && bit_cnt_ff < width_ff) begin
      shift_ff   <= {shift_ff[30:0], sdi};
      bit_cnt_ff <= bit_cnt_ff + 6'h01;
    end else if (state_ff == ST_WRITE && sck_rise && bit_cnt_ff == width_ff) begin
      bit_cnt_ff <= 6'h00;                              // Extra bits ignored after commit
      width_ff   <= WID_NONE;
    end
  end

  // Data pin driver: enabled on the first falling edge of a read
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      oe_n_ff <= 1'b1;
      sdo_ff  <= 1'b0;
    end else if (state_ff != ST_READ || ~sel_active) begin
      oe_n_ff <= 1'b1;
      sdo_ff  <= 1'b0;
    end else if (sck_fall) begin
      oe_n_ff <= 1'b0;
      if (invalid_ff) begin
        sdo_ff <= (bit_cnt_ff < INVALID_ONES);
      end else if (bit_cnt_ff < width_ff) begin
        sdo_ff <= shift_ff[31];
      end else begin
        sdo_ff <= 1'b0;
      end
    end
  end

  assign serial_data_out      = sdo_ff;
  assign serial_data_oe_n_out = oe_n_ff;

  // Software reset pulse on any write to the clear register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= write_commit & (addr_ff == ADR_SW_CLEAR);
    end
  end

  // Register array; reset and software reset restore defaults
  for (genvar g = 0; g < 16; g++) begin : g_reg
    always_ff @(posedge core_clk_in) begin
      if (rst_in || soft_rst_ff) begin
        regs_ff[g] <= default_of(g);
      end else if (write_commit && addr_ff == 4'(g) && g != int'(ADR_SW_CLEAR)) begin
        regs_ff[g] <= merged;
      end
    end
  end

  // Threshold, hysteresis and level widened so the sums cannot wrap
  assign thr = {2'h0, main_ctrl[THR_HI:THR_LO]};
  assign hys = {5'h00, main_ctrl[HYS_HI:HYS_LO]};
  assign lvl = {2'h0, signal_level_in};

  // Received data validation with signal level hysteresis
  always_ff @(posedge core_clk_in) begin
    if (rst_in || soft_rst_ff || ~main_ctrl[BIT_POWER]) begin
      data_valid_ff <= 1'b0;
    end else if (lvl >= thr + hys) begin
      data_valid_ff <= 1'b1;
    end else if (lvl + hys < thr) begin
      data_valid_ff <= 1'b0;
    end
  end

  assign radio_data_pin_out = radio_data_pin_in & data_valid_ff;

  // Control decode from main control, function reset from the software reset pulse
  always_comb begin
    ctrl_out.global_power_on        = main_ctrl[BIT_POWER];
    ctrl_out.radio_direction        = main_ctrl[BIT_DIRECTION];
    ctrl_out.recovered_clock_enable = main_ctrl[BIT_POWER] & main_ctrl[BIT_REC_CLK];
    ctrl_out.transmit_enable        = main_ctrl[BIT_POWER] & main_ctrl[BIT_DIRECTION] &
                                      (~main_ctrl[BIT_TX_ON_LOCK] | synth_lock_flag_in);
    ctrl_out.amplifier_power_on     = main_ctrl[BIT_AMP_POWER] & main_ctrl[BIT_POWER];
    ctrl_out.wakeup_enable          = main_ctrl[BIT_WAKEUP_EN] & main_ctrl[BIT_POWER];
    ctrl_out.radio_blocks_hold      = ~main_ctrl[BIT_POWER];
    ctrl_out.function_reset         = soft_rst_ff;
  end

  // Checks
  sequence s_read_hdr;
    read_begin;
  endsequence

  sequence s_read_fall;
    (state_ff == ST_READ) && sel_active && sck_fall;
  endsequence

  chk_read_entry: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_read_hdr |=> (state_ff == ST_READ) && serial_data_oe_n_out)
    else $error("read header did not open a read with pin released");

  chk_pin_turn: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_read_fall |=> !serial_data_oe_n_out)
    else $error("data pin not driven after falling edge");

  chk_msb_order: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_read_fall ##0 (!invalid_ff && bit_cnt_ff < width_ff) |=>
      serial_data_out == $past(shift_ff[31]))
    else $error("read bit is not next shifter bit");

  chk_over_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_read_fall ##0 (!invalid_ff && bit_cnt_ff >= width_ff) |=> !serial_data_out)
    else $error("over-read bit not low");

  chk_invalid_ones: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_read_fall ##0 (invalid_ff && bit_cnt_ff < INVALID_ONES) |=> serial_data_out)
    else $error("invalid address bit not high in first 32");

  chk_pin_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !sel_active |=> serial_data_oe_n_out)
    else $error("data pin still driven after select high");

  chk_soft_reset: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (write_commit && addr_ff == ADR_SW_CLEAR) |=> soft_rst_ff ##1
      (regs_ff[ADR_MAIN_CTRL] == RST_MAIN_CTRL && !ctrl_out.global_power_on))
    else $error("clear write did not restore main control");

  chk_amp_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ctrl_out.amplifier_power_on |-> main_ctrl[BIT_POWER] && main_ctrl[BIT_AMP_POWER])
    else $error("amplifier on without both power bits");

  chk_tx_lock: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ctrl_out.transmit_enable && main_ctrl[BIT_TX_ON_LOCK]) |-> synth_lock_flag_in)
    else $error("transmit without lock while gated");

  chk_idle_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_ff == ST_IDLE && !sel_active) |=> (state_ff == ST_IDLE) && serial_data_oe_n_out)
    else $error("deselected port left idle");

  chk_trunc_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_ff == ST_READ && !sel_active) |=> !soft_rst_ff && (state_ff == ST_IDLE))
    else $error("truncated read caused side effect");

  chk_access_end: assert property (@(posedge core_clk_in) disable iff (rst_in)
    end_access |=> (state_ff == ST_IDLE) && serial_data_oe_n_out)
    else $error("access not closed after select high");

  chk_invalid_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_read_fall ##0 (invalid_ff && bit_cnt_ff >= INVALID_ONES) |=> !serial_data_out)
    else $error("invalid address bit not low after 32");

  chk_reserved_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (read_begin && addr_ff > ADR_SW_CLEAR && addr_ff < ADR_LOCK_CTRL) |=> invalid_ff)
    else $error("reserved address not read as invalid");

  chk_trim_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (write_commit && addr_ff == ADR_SLICER_TRIM) |=> regs_ff[ADR_SLICER_TRIM] == $past(merged))
    else $error("slicer trim write not stored");

  chk_soft_defaults: assert property (@(posedge core_clk_in) disable iff (rst_in)
    soft_rst_ff |=> regs_ff[ADR_SLICER_TRIM] == RST_SLICER &&
      regs_ff[ADR_LOCK_CTRL] == RST_OTHER)
    else $error("software reset left a register changed");

  chk_power_valid: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !main_ctrl[BIT_POWER] |=> !data_valid_ff)
    else $error("data still valid in power-down");

  chk_hys_on: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (main_ctrl[BIT_POWER] && !soft_rst_ff && lvl >= thr + hys) |=> data_valid_ff)
    else $error("data not validated above upper level");

  chk_hys_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (lvl + hys < thr) |=> !data_valid_ff)
    else $error("data not inhibited below lower level");

endmodule
`default_nettype wire

/* shared/rfsrb_pkg.sv */
// Functional notes
// - Direction bit 0 selects read, sampled rising
// - Read data changes on falling edges, MSB first
// - Data pin turns output after direction capture
// - Select high ends read anytime, no side effects
// - Bits beyond register width read as zero
// - Invalid address: ones for 32 periods, then zeros
// - Data pin returns to input on select high
// - Slicer trim at 0110, 6 bits, read/write
// - Wake-up rate at 1000, 18 bits, read/write
// - 1111 lock/recovery control 32 bits; 1100-1110 reserved
// - Any write to 1011 resets the device
// - Software reset restores defaults and powers down
// - Power-down holds radio sub-blocks in reset
// - Main control resets to 10000270 hex
// - Bit 31 global power switch, resets 0
// - Bit 30 selects receive or transmit
// - Bit 29 enables recovered clock output
// - Bit 28 gates transmit on synthesizer lock
// - Amplifier on only with bits 27 and 31
// - Select high ignores clock; one register per access
// - Wake-up enable 0 disables wake-up function
// - Signal level hysteresis validates received data
package rfsrb_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam int          CNT_W           = 6;
  // Register addresses
  localparam logic [3:0]  ADR_FREQ_CODE_0 = 4'h0;
  localparam logic [3:0]  ADR_FREQ_CODE_3 = 4'h3;
  localparam logic [3:0]  ADR_MAIN_CTRL   = 4'h4;
  localparam logic [3:0]  ADR_STATUS      = 4'h5;
  localparam logic [3:0]  ADR_SLICER_TRIM = 4'h6;
  localparam logic [3:0]  ADR_WAKEUP_CTRL = 4'h7;
  localparam logic [3:0]  ADR_WAKEUP_RATE = 4'h8;
  localparam logic [3:0]  ADR_WAKEUP_ADDR = 4'h9;
  localparam logic [3:0]  ADR_WAKEUP_WORD = 4'hA;
  localparam logic [3:0]  ADR_SW_CLEAR    = 4'hB;
  localparam logic [3:0]  ADR_LOCK_CTRL   = 4'hF;
  // Register widths in bits
  localparam logic [5:0]  WID_FULL        = 6'h20;
  localparam logic [5:0]  WID_STATUS      = 6'h1F;
  localparam logic [5:0]  WID_SLICER      = 6'h06;
  localparam logic [5:0]  WID_WU_RATE     = 6'h12;
  localparam logic [5:0]  WID_WU_ADDR     = 6'h19;
  localparam logic [5:0]  WID_SW_CLEAR    = 6'h01;
  localparam logic [5:0]  WID_NONE        = 6'h00;
  // Invalid address read pattern length in clock periods
  localparam logic [5:0]  INVALID_ONES    = 6'h20;
  localparam logic [5:0]  CNT_MAX         = 6'h3F;
  localparam logic [2:0]  ADDR_RW_LAST    = 3'h4;
  // Reset values
  localparam logic [31:0] RST_MAIN_CTRL   = 32'h1000_0270;
  localparam logic [31:0] RST_SLICER      = 32'h0000_0020;
  localparam logic [31:0] RST_OTHER       = 32'h0000_0000;
  // Main control field positions
  localparam int          BIT_POWER       = 31;
  localparam int          BIT_DIRECTION   = 30;
  localparam int          BIT_REC_CLK     = 29;
  localparam int          BIT_TX_ON_LOCK  = 28;
  localparam int          BIT_AMP_POWER   = 27;
  localparam int          BIT_WAKEUP_EN   = 26;
  localparam int          THR_HI          = 23;
  localparam int          THR_LO          = 18;
  localparam int          HYS_HI          = 17;
  localparam int          HYS_LO          = 15;

  // Serial access states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_READ  = 4'b0100,
    ST_WRITE = 4'b1000
  } rfsrb_state_t;

  // Radio control outputs decoded from main control, plus the software reset pulse
  typedef struct packed {
    logic global_power_on;
    logic radio_direction;
    logic recovered_clock_enable;
    logic transmit_enable;
    logic amplifier_power_on;
    logic wakeup_enable;
    logic radio_blocks_hold;
    logic function_reset;
  } rfsrb_ctrl_t;

endpackage

/* verification/rfsrb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rfsrb_host_model
  import rfsrb_pkg::*;
#(
  parameter int HALF = 6
) (
  input  wire logic core_clk_in,         // Core clock used for pacing
  output logic      serial_select_n_out, // Access select, active low
  output logic      serial_clk_out,      // Serial clock, idle low
  output logic      host_data_out,       // Value the host drives
  output logic      host_drive_out,      // High while the host drives data
  input  wire logic pin_in               // Resolved data wire
);
  // Idle link: select high, clock still, data released
  initial begin
    serial_select_n_out = 1'b1;
    serial_clk_out      = 1'b0;
    host_data_out       = 1'b0;
    host_drive_out      = 1'b0;
  end

  // Moves just after a core clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // Bits go out MSB first, sampled by the device on the rising edge
  task automatic send_bits(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      host_data_out = v[31-i];
      wait_clk(HALF);
      serial_clk_out = 1'b1;
      wait_clk(HALF);
      serial_clk_out = 1'b0;
    end
  endtask

  // One register per framed access
  task automatic open_frame();
    serial_select_n_out = 1'b0;
    wait_clk(HALF);
  endtask

  task automatic close_frame();
    wait_clk(HALF);
    serial_select_n_out = 1'b1;
    wait_clk(HALF);
  endtask

  // Header with direction 0, then release the wire at the turnaround fall
  task automatic start_read(input logic [3:0] a);
    open_frame();
    host_drive_out = 1'b1;
    send_bits({a, 1'b0, 27'h0}, 5);
    host_drive_out = 1'b0;
    wait_clk(HALF);
  endtask

  // Samples at each rising edge; may stop after any count
  task automatic read_bits(input int n, output logic [39:0] q);
    q = '0;
    for (int i = 0; i < n; i++) begin
      serial_clk_out = 1'b1;
      q = {q[38:0], pin_in};
      wait_clk(HALF);
      serial_clk_out = 1'b0;
      wait_clk(HALF);
    end
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [31:0] v, input int n);
    open_frame();
    host_drive_out = 1'b1;
    send_bits({a, 1'b1, 27'h0}, 5);
    send_bits(v, n);
    host_drive_out = 1'b0;
    close_frame();
  endtask

  // Clock and data activity while the device is not selected
  task automatic noise();
    host_drive_out = 1'b1;
    for (int i = 0; i < 16; i++) begin
      host_data_out = i[1];
      wait_clk(HALF);
      serial_clk_out = ~serial_clk_out;
    end
    host_drive_out = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/rfsrb_regbank_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rfsrb_regbank_tb_top
  import rfsrb_pkg::*;
;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wval;
    int          wbits;
    logic [33:0] exp;
  } rfsrb_row_t;

  localparam logic [33:0] INV = {32'hFFFF_FFFF, 2'h0};
  localparam rfsrb_row_t ROWS [13] = '{
    '{4'h4, 32'h0, 0, {32'h1000_0270, 2'h0}},
    '{4'h6, 32'h0, 0, {6'h20, 28'h0}},
    '{4'h0, 32'h1234_5678, 32, {32'h1234_5678, 2'h0}},
    '{4'h3, 32'hFEDC_BA98, 32, {32'hFEDC_BA98, 2'h0}},
    '{4'h6, 32'hAC00_0000, 6, {6'h2B, 28'h0}},
    '{4'h8, 32'hF0F0_C000, 18, {18'h3C3C3, 16'h0}},
    '{4'hF, 32'hA5A5_0F0F, 32, {32'hA5A5_0F0F, 2'h0}},
    '{4'hC, 32'hFFFF_FFFF, 32, INV},
    '{4'hD, 32'h0, 0, INV},
    '{4'hE, 32'h0, 0, INV},
    '{4'hB, 32'h0, 0, INV},
    '{4'hA, 32'h0, 32, {32'h5A5A_C3C3, 2'h0}},
    '{4'h5, 32'hFFFF_FFFF, 31, {31'h1234_5678, 3'h0}}
  };
  localparam logic [31:0] CV [4] = '{32'h0800_0000, 32'hDC00_0000, 32'hC800_0000, 32'hA000_0000};

  logic        core_clk;
  logic        rst;
  logic        sel_n;
  logic        sclk;
  logic        host_val;
  logic        host_drive;
  logic        pin;
  logic        sd_out;
  logic        sd_oe_n;
  logic [30:0] status_flags;
  logic        lock;
  logic [31:0] wu_word;
  logic [5:0]  level;
  logic        rdata_in;
  logic        rdata_out;
  rfsrb_ctrl_t ctrl;
  int          errors;
  int          compares;
  int          fr_pulses;

  // Counts software reset pulses on the control outputs
  always @(posedge core_clk) begin
    if (rst) begin
      fr_pulses <= 0;
    end else if (ctrl.function_reset) begin
      fr_pulses <= fr_pulses + 1;
    end
  end

  // Wire level: device, else host, else pull-up
  assign pin = !sd_oe_n ? sd_out : (host_drive ? host_val : 1'b1);

  rfsrb_regbank rfsrb_regbank_i (
    .core_clk_in          (core_clk),
    .rst_in               (rst),
    .serial_select_n_in   (sel_n),
    .serial_clk_in        (sclk),
    .serial_data_in       (pin),
    .serial_data_out      (sd_out),
    .serial_data_oe_n_out (sd_oe_n),
    .status_flags_in      (status_flags),
    .synth_lock_flag_in   (lock),
    .wakeup_word_in       (wu_word),
    .signal_level_in      (level),
    .radio_data_pin_in    (rdata_in),
    .radio_data_pin_out   (rdata_out),
    .ctrl_out             (ctrl)
  );

  rfsrb_host_model rfsrb_host_model_i (
    .core_clk_in         (core_clk),
    .serial_select_n_out (sel_n),
    .serial_clk_out      (sclk),
    .host_data_out       (host_val),
    .host_drive_out      (host_drive),
    .pin_in              (pin)
  );

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Full read of 34 bits, with pin direction checks around it
  task automatic rd(input logic [3:0] a, output logic [33:0] q);
    logic [39:0] raw;
    rfsrb_host_model_i.start_read(a);
    chk({33'h0, sd_oe_n}, 34'h0);
    rfsrb_host_model_i.read_bits(34, raw);
    rfsrb_host_model_i.close_frame();
    chk({33'h0, sd_oe_n}, 34'h1);
    q = raw[33:0];
  endtask

  function automatic logic [7:0] exp_ctrl(input logic [31:0] v, input logic l);
    logic p;
    p = v[31];
    return {p, v[30], v[29] & p, p & v[30] & (~v[28] | l), v[27] & p, v[26] & p, ~p, 1'b0};
  endfunction

  // Watchdog
  initial begin
    #400000;
    errors++;
    results();
  end

  // Main sequence
  initial begin
    logic [33:0] q;
    logic [39:0] raw;
    logic [5:0]  lv [5];
    logic        ev [5];
    errors       = 0;
    compares     = 0;
    rst          = 1'b1;
    status_flags = 31'h1234_5678;
    lock         = 1'b0;
    wu_word      = 32'h5A5A_C3C3;
    level        = 6'h00;
    rdata_in     = 1'b1;
    lv = '{6'd13, 6'd9, 6'd7, 6'd9, 6'd12};
    ev = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    step(5);
    rst = 1'b0;
    step(3);
    // Table of writes and read-backs
    foreach (ROWS[i]) begin
      if (ROWS[i].wbits > 0) begin
        rfsrb_host_model_i.write_reg(ROWS[i].addr, ROWS[i].wval, ROWS[i].wbits);
      end
      rd(ROWS[i].addr, q);
      chk(q, ROWS[i].exp);
    end
    // Traffic with select high must leave registers alone
    rfsrb_host_model_i.noise();
    rd(4'h0, q);
    chk(q, {32'h1234_5678, 2'h0});
    // Truncated read then a full one
    rfsrb_host_model_i.start_read(4'h3);
    rfsrb_host_model_i.read_bits(3, raw);
    rfsrb_host_model_i.close_frame();
    chk({31'h0, raw[2:0]}, {31'h0, 3'b111});
    rd(4'h3, q);
    chk(q, {32'hFEDC_BA98, 2'h0});
    // Control field decode with and without lock
    for (int k = 0; k < 8; k++) begin
      if (!k[0]) begin
        rfsrb_host_model_i.write_reg(4'h4, CV[k/2], 32);
      end
      lock = k[0];
      step(4);
      chk({26'h0, ctrl}, {26'h0, exp_ctrl(CV[k/2], k[0])});
    end
    // Received data validation with hysteresis, threshold 10, hysteresis 2
    rfsrb_host_model_i.write_reg(4'h4, 32'h8029_0000, 32);
    for (int k = 0; k < 5; k++) begin
      level = lv[k];
      step(6);
      chk({33'h0, rdata_out}, {33'h0, ev[k]});
    end
    // Software reset after changing registers
    rfsrb_host_model_i.write_reg(4'h6, 32'h5400_0000, 6);
    rfsrb_host_model_i.write_reg(4'hB, 32'h0, 1);
    step(1000);
    rd(4'h4, q);
    chk(q, {32'h1000_0270, 2'h0});
    rd(4'h6, q);
    chk(q, {6'h20, 28'h0});
    chk({26'h0, ctrl}, {26'h0, 8'h02});
    chk({33'h0, rdata_out}, 34'h0);
    chk(34'(fr_pulses), 34'h1);
    results();
  end
endmodule
`default_nettype wire
